// >>> pkg/asc_regs.svh
// timing counts and field positions for the converter sequence controller
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_NUM_CH 12
`define ASC_RES_W 12
`define ASC_CONV_CYCLES 16
`define ASC_CAL_CYCLES 64
`define ASC_ST_THR_IRQ 0
`define ASC_ST_OVR_IRQ 1
`define ASC_ST_SEQ0_IRQ 2
`define ASC_ST_SEQ1_IRQ 3
`define ASC_ST_OVR_SEQ0 4
`define ASC_ST_OVR_SEQ1 5
`define ASC_ST_W 6
`define ASC_THR_OFF 2'h0
`define ASC_THR_OUTSIDE 2'h1
`define ASC_THR_CROSS 2'h2
`endif

// >>> pkg/asc_pkg.sv
// types shared by the converter sequence controller
package asc_pkg;
   typedef logic [11:0] asc_chmask_t;
   typedef logic [11:0] asc_sample_t;
   typedef logic [23:0] asc_thrmode_t;
   typedef struct packed {
      logic ready;
      logic overrun;
      logic [3:0] channel;
      logic [11:0] value;
   } asc_result_t;
endpackage : asc_pkg

// >>> pkg/asc_conv_if.sv
// handshake between the sequencer and the conversion engine
`timescale 1ns/1ps
interface asc_conv_if;
   logic start;
   logic [3:0] channel;
   logic busy;
   logic done;
   logic [11:0] value;
   modport ctrl (output start, output channel, input busy, input done, input value);
   modport eng (input start, input channel, output busy, output done, output value);
endinterface : asc_conv_if

// >>> src/asc_conv_engine.sv
// conversion engine: fixed-length conversion timer around the analog sample
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_conv_engine #(
   parameter int CONV_CYCLES = `ASC_CONV_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] sample_in,
   asc_conv_if.eng cv
);
   logic [7:0] cnt_r;
   logic busy_r;
   logic done_r;
   logic [11:0] val_r;

   assign cv.busy = busy_r;
   assign cv.done = done_r;
   assign cv.value = val_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         val_r <= 12'h000;
      end else begin
         done_r <= 1'b0;
         if (!busy_r && cv.start) begin
            busy_r <= 1'b1;
            cnt_r <= 8'(CONV_CYCLES - 1);
         end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
               val_r <= sample_in;
            end else begin
               cnt_r <= cnt_r - 8'h01;
            end
         end
      end
   end

   a_done_after_conv: assert property (@(posedge clk_sys) disable iff (rst)
      (!busy_r && cv.start) |-> ##(CONV_CYCLES + 1) done_r)
      else $error("conversion did not finish on time");
endmodule : asc_conv_engine

// >>> src/asc_seq_ctrl.sv
// two-sequence conversion controller with results, thresholds and status flags
//
// Behaviour
// - disabled sequence drops hardware and software triggers
// - continuous cycling restarts the sequence back to back without triggers
// - continuous cycling ignores every other trigger for that sequence
// - clearing continuous cycling lets the running pass finish
// - a pass launched as cycling is cleared also completes
// - software start launches one pass on an enabled sequence
// - either sequence may be marked high priority
// - high-priority trigger preempts a running low-priority pass
// - per-sequence global result with ready indication
// - per-channel latest result with ready indication
// - two writable 12-bit low/high limit windows
// - channel mask picks limit window zero or one
// - per-channel threshold interrupt enable chooses its mode
// - modes: off, outside the window, or crossing the threshold
// - block interrupt enables for each sequence and overrun
// - per-sequence choice: flag per conversion or per whole sequence
// - hardware trigger edge chosen by per-sequence polarity
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_seq_ctrl
   import asc_pkg::*;
#(
   parameter int NUM_CH = `ASC_NUM_CH,
   parameter int CONV_CYCLES = `ASC_CONV_CYCLES,
   parameter int CAL_CYCLES = `ASC_CAL_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] sample_in,
   input wire logic [1:0] seq_enable,
   input wire logic [1:0] seq_sw_start,
   input wire logic [1:0] continuous_cycling,
   input wire logic [1:0] seq_high_prio,
   input wire logic [1:0] trig_pin,
   input wire logic [1:0] trig_rising,
   input wire logic [1:0] seq_irq_per_seq,
   input wire asc_pkg::asc_chmask_t first_conversion_sequence,
   input wire asc_pkg::asc_chmask_t second_conversion_sequence,
   input wire asc_pkg::asc_sample_t limit_window_zero_low,
   input wire asc_pkg::asc_sample_t limit_window_zero_high,
   input wire asc_pkg::asc_sample_t limit_window_one_low,
   input wire asc_pkg::asc_sample_t limit_window_one_high,
   input wire asc_pkg::asc_chmask_t limit_window_one_sel,
   input wire asc_pkg::asc_thrmode_t thr_mode,
   input wire logic [2:0] block_irq_en,
   input wire logic [5:0] status_clear,
   input wire asc_pkg::asc_chmask_t thr_flag_clear,
   input wire logic cal_start,
   output logic cal_busy,
   output logic cal_ok,
   output logic [5:0] status_flags,
   output asc_pkg::asc_chmask_t thr_flags,
   output logic irq,
   output asc_pkg::asc_result_t seq0_result,
   output asc_pkg::asc_result_t seq1_result,
   output logic [NUM_CH*18-1:0] chan_results
);
   import asc_pkg::*;

   typedef enum logic [1:0] {
      ASC_IDLE = 2'b00,
      ASC_CAL = 2'b01,
      ASC_CONV = 2'b10,
      ASC_WAIT = 2'b11
   } asc_state_t;

   asc_conv_if cv ();
   asc_conv_engine #(.CONV_CYCLES(CONV_CYCLES)) u_eng (
      .clk_sys(clk_sys),
      .rst(rst),
      .sample_in(sample_in),
      .cv(cv)
   );

   asc_state_t state_r;
   logic [1:0] trig_m_r, trig_s_r, trig_d_r;
   logic [1:0] pend_r;
   logic [1:0] active_r;
   logic cur_r;
   logic [3:0] ch_r;
   logic [11:0] left_r;
   logic [7:0] cal_cnt_r;
   logic start_r;
   logic cal_busy_r, cal_ok_r;
   logic [5:0] status_r;
   asc_chmask_t thr_r;
   logic irq_r;
   asc_result_t gres_r [2];
   asc_result_t cres_r [NUM_CH];
   logic [NUM_CH-1:0] above_r;

   logic [1:0] hw_edge, req, grant_ok, lose;
   logic last_conv;
   logic [11:0] seq_mask [2];
   asc_chmask_t thr_set;
   logic [5:0] status_set;
   logic [3:0] first_ch [2];
   logic [3:0] next_ch;

   assign seq_mask[0] = first_conversion_sequence;
   assign seq_mask[1] = second_conversion_sequence;
   assign cv.start = start_r;
   assign cv.channel = ch_r;

   // two-flop sync then edge detect per trigger pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trig_m_r <= 2'h0;
         trig_s_r <= 2'h0;
         trig_d_r <= 2'h0;
      end else begin
         trig_m_r <= trig_pin;
         trig_s_r <= trig_m_r;
         trig_d_r <= trig_s_r;
      end
   end

   always_comb begin
      for (int s = 0; s < 2; s++) begin
         hw_edge[s] = trig_rising[s] ? (trig_s_r[s] & ~trig_d_r[s])
                                     : (~trig_s_r[s] & trig_d_r[s]);
         first_ch[s] = 4'h0;
         for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (seq_mask[s][c]) first_ch[s] = 4'(c);
         end
      end
      next_ch = 4'hf;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (left_r[c] && 4'(c) != ch_r) next_ch = 4'(c);
      end
      last_conv = (left_r & ~(12'h001 << ch_r)) == 12'h000;
      lose = 2'h0;
      if (state_r == ASC_WAIT && cv.done && !last_conv && req[!cur_r]
          && seq_high_prio[!cur_r] && !seq_high_prio[cur_r]) lose[cur_r] = 1'b1;
   end

   // pending requests; cycling masks all triggers and re-arms itself
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend_r <= 2'h0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (!seq_enable[s] || seq_mask[s] == 12'h000) begin
               pend_r[s] <= 1'b0;
            end else if (continuous_cycling[s]) begin
               pend_r[s] <= !active_r[s] && !grant_ok[s];
            end else if (seq_sw_start[s] || hw_edge[s] || lose[s]) begin
               pend_r[s] <= 1'b1;
            end else if (grant_ok[s]) begin
               pend_r[s] <= 1'b0;
            end
         end
      end
   end

   assign req = pend_r & seq_enable;
   always_comb begin
      grant_ok = 2'h0;
      if (state_r == ASC_IDLE && !cal_busy_r) begin
         if (req[1] && (seq_high_prio[1] || !req[0])) grant_ok = 2'b10;
         else if (req[0]) grant_ok = 2'b01;
      end
   end

   // sequencer: calibration, pass launch, channel walk, preemption
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= ASC_IDLE;
         active_r <= 2'h0;
         cur_r <= 1'b0;
         ch_r <= 4'h0;
         left_r <= 12'h000;
         start_r <= 1'b0;
         cal_cnt_r <= 8'h00;
         cal_busy_r <= 1'b0;
         cal_ok_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         unique case (state_r)
            ASC_IDLE: begin
               if (cal_start) begin
                  state_r <= ASC_CAL;
                  cal_busy_r <= 1'b1;
                  cal_ok_r <= 1'b0;
                  cal_cnt_r <= 8'(CAL_CYCLES - 1);
               end else if (grant_ok != 2'h0) begin
                  cur_r <= grant_ok[1];
                  active_r <= grant_ok;
                  left_r <= seq_mask[grant_ok[1]];
                  ch_r <= first_ch[grant_ok[1]];
                  start_r <= 1'b1;
                  state_r <= ASC_CONV;
               end
            end
            ASC_CAL: begin
               if (cal_cnt_r == 8'h00) begin
                  cal_busy_r <= 1'b0;
                  cal_ok_r <= 1'b1;
                  state_r <= ASC_IDLE;
               end else begin
                  cal_cnt_r <= cal_cnt_r - 8'h01;
               end
            end
            ASC_CONV: begin
               state_r <= ASC_WAIT;
            end
            ASC_WAIT: begin
               if (cv.done) begin
                  // a started pass finishes, cycling or not, unless a high-priority request preempts it between conversions
                  if (last_conv) begin
                     active_r <= 2'h0;
                     state_r <= ASC_IDLE;
                  end else if (lose != 2'h0) begin
                     active_r <= 2'h0;
                     state_r <= ASC_IDLE;
                  end else begin
                     left_r <= left_r & ~(12'h001 << ch_r);
                     ch_r <= next_ch;
                     start_r <= 1'b1;
                     state_r <= ASC_CONV;
                  end
               end
            end
         endcase
      end
   end

   // status set terms: sequence flag per conversion or at pass end, overrun when the channel already holds a ready result
   always_comb begin
      status_set = 6'h00;
      if (state_r == ASC_WAIT && cv.done) begin
         if (!seq_irq_per_seq[cur_r] || last_conv)
            status_set[`ASC_ST_SEQ0_IRQ + int'(cur_r)] = 1'b1;
         if (cres_r[ch_r].ready)
            status_set[`ASC_ST_OVR_SEQ0 + int'(cur_r)] = 1'b1;
      end
      status_set[`ASC_ST_OVR_IRQ] = |status_set[5:4];
   end

   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic hit, outside, hi_now;
         logic [11:0] lo, hi;
         assign lo = limit_window_one_sel[c] ? limit_window_one_low : limit_window_zero_low;
         assign hi = limit_window_one_sel[c] ? limit_window_one_high : limit_window_zero_high;
         assign hit = state_r == ASC_WAIT && cv.done && ch_r == 4'(c);
         assign outside = cv.value < lo || cv.value > hi;
         assign hi_now = cv.value >= lo;
         always_comb begin
            unique case (thr_mode[2*c +: 2])
               `ASC_THR_OUTSIDE: thr_set[c] = hit && outside;
               `ASC_THR_CROSS: thr_set[c] = hit && cres_r[c].ready && hi_now != above_r[c];
               default: thr_set[c] = 1'b0;
            endcase
         end
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               cres_r[c] <= '0;
               above_r[c] <= 1'b0;
            end else if (hit) begin
               cres_r[c] <= '{1'b1, cres_r[c].ready, 4'(c), cv.value};
               above_r[c] <= hi_now;
            end
         end
         assign chan_results[c*18 +: 18] = cres_r[c];
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) thr_r[c] <= 1'b0;
            else if (thr_set[c]) thr_r[c] <= 1'b1;
            else if (thr_flag_clear[c]) thr_r[c] <= 1'b0;
         end
      end
   endgenerate

   // global results per sequence
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gres_r[0] <= '0;
         gres_r[1] <= '0;
      end else if (state_r == ASC_WAIT && cv.done) begin
         gres_r[cur_r] <= '{1'b1, gres_r[cur_r].ready, ch_r, cv.value};
      end
   end

   // status word: set wins over the write-one clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_r <= 6'h00;
         irq_r <= 1'b0;
      end else begin
         status_r[5:1] <= status_set[5:1] | (status_r[5:1] & ~status_clear[5:1]);
         status_r[`ASC_ST_THR_IRQ] <= |thr_set | (|thr_r & ~status_clear[0]);
         irq_r <= (block_irq_en[0] & status_r[`ASC_ST_SEQ0_IRQ])
                | (block_irq_en[1] & status_r[`ASC_ST_SEQ1_IRQ])
                | (block_irq_en[2] & status_r[`ASC_ST_OVR_IRQ])
                | status_r[`ASC_ST_THR_IRQ];
      end
   end

   assign cal_busy = cal_busy_r;
   assign cal_ok = cal_ok_r;
   assign status_flags = status_r;
   assign thr_flags = thr_r;
   assign irq = irq_r;
   assign seq0_result = gres_r[0];
   assign seq1_result = gres_r[1];

   a_disabled_no_pass: assert property (@(posedge clk_sys) disable iff (rst)
      (state_r == ASC_IDLE && !seq_enable[0] && !seq_enable[1]) |=> state_r != ASC_CONV)
      else $error("pass started on disabled sequence");
   a_cycling_rearm: assert property (@(posedge clk_sys) disable iff (rst)
      (seq_enable[0] && continuous_cycling[0] && seq_mask[0] != 12'h000 && !active_r[0])
      |=> (pend_r[0] || active_r[0]))
      else $error("cycling did not re-arm");
   a_result_ready: assert property (@(posedge clk_sys) disable iff (rst)
      (state_r == ASC_WAIT && cv.done) |=> gres_r[cur_r].ready)
      else $error("global result not ready");
   a_status_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      (status_r[2] && !status_clear[2]) |=> status_r[2])
      else $error("sequence flag lost");
   sequence s_low_preempted;
      state_r == ASC_WAIT && cv.done && !last_conv && req[!cur_r] && seq_high_prio[!cur_r]
         && !seq_high_prio[cur_r];
   endsequence
   a_high_preempts: assert property (@(posedge clk_sys) disable iff (rst)
      s_low_preempted |=> (state_r == ASC_IDLE && pend_r[!cur_r]))
      else $error("high priority request did not preempt");
endmodule : asc_seq_ctrl

// >>> dv/tb_asc_seq_ctrl.sv
// self-checking bench for the two-sequence converter controller
`timescale 1ns/1ps
`include "asc_regs.svh"
module tb_asc_seq_ctrl;
   import asc_pkg::*;
   logic clk_sys;
   logic rst;
   logic [11:0] sample_in;
   logic [1:0] seq_enable, seq_sw_start, continuous_cycling, seq_high_prio;
   logic [1:0] trig_pin, trig_rising, seq_irq_per_seq;
   asc_chmask_t first_conversion_sequence, second_conversion_sequence;
   asc_chmask_t limit_window_one_sel, thr_flag_clear, thr_flags;
   asc_sample_t limit_window_zero_low, limit_window_zero_high;
   asc_sample_t limit_window_one_low, limit_window_one_high;
   asc_thrmode_t thr_mode;
   logic [2:0] block_irq_en;
   logic [5:0] status_clear, status_flags;
   logic cal_start, cal_busy, cal_ok, irq;
   asc_result_t seq0_result, seq1_result, prev0, prev1;
   logic [12*18-1:0] chan_results;
   logic [15:0] obs [2][$];
   logic [11:0] m, smp;
   int num_errors, checks, cycles;
   logic [1:0] tmode [5] = '{`ASC_THR_OFF, `ASC_THR_OUTSIDE, `ASC_THR_OUTSIDE, `ASC_THR_CROSS,
                             `ASC_THR_CROSS};
   logic [11:0] tsmp [5] = '{12'h300, 12'h310, 12'h150, 12'h050, 12'h060};
   logic texp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

   asc_seq_ctrl #(.NUM_CH(12), .CONV_CYCLES(16), .CAL_CYCLES(4)) asc_seq_ctrl_inst (
      .clk_sys(clk_sys), .rst(rst), .sample_in(sample_in), .seq_enable(seq_enable),
      .seq_sw_start(seq_sw_start), .continuous_cycling(continuous_cycling),
      .seq_high_prio(seq_high_prio), .trig_pin(trig_pin), .trig_rising(trig_rising),
      .seq_irq_per_seq(seq_irq_per_seq), .first_conversion_sequence(first_conversion_sequence),
      .second_conversion_sequence(second_conversion_sequence),
      .limit_window_zero_low(limit_window_zero_low),
      .limit_window_zero_high(limit_window_zero_high),
      .limit_window_one_low(limit_window_one_low), .limit_window_one_high(limit_window_one_high),
      .limit_window_one_sel(limit_window_one_sel), .thr_mode(thr_mode),
      .block_irq_en(block_irq_en), .status_clear(status_clear), .thr_flag_clear(thr_flag_clear),
      .cal_start(cal_start), .cal_busy(cal_busy), .cal_ok(cal_ok), .status_flags(status_flags),
      .thr_flags(thr_flags), .irq(irq), .seq0_result(seq0_result), .seq1_result(seq1_result),
      .chan_results(chan_results));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // model side: every fresh global result is queued as {channel, value}
   always @(posedge clk_sys) begin
      prev0 <= seq0_result;
      prev1 <= seq1_result;
      if (seq0_result.ready === 1'b1 && seq0_result !== prev0)
         obs[0].push_back({seq0_result.channel, seq0_result.value});
      if (seq1_result.ready === 1'b1 && seq1_result !== prev1)
         obs[1].push_back({seq1_result.channel, seq1_result.value});
   end

   // hang guard, far above the thousand-odd cycles the tests need
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick

   task automatic wait_obs(input int s, input int n);
      int t;
      t = 0;
      while (obs[s].size() < n && t < 2000) begin
         tick(1);
         t++;
      end
      if (obs[s].size() < n) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, obs[s].size(), n);
      end
   endtask : wait_obs

   // channels come out ascending with the held sample; per-channel copies follow
   task automatic pass_check(input int s, input logic [11:0] mk, input logic [11:0] v);
      logic [15:0] e;
      for (int c = 0; c < 12; c++) begin
         if (mk[c]) begin
            wait_obs(s, 1);
            e = (obs[s].size() > 0) ? obs[s].pop_front() : 16'hffff;
            check({16'h0, e}, {16'h0, c[3:0], v});
         end
      end
      tick(2);
      for (int c = 0; c < 12; c++) begin
         if (mk[c])
            check({chan_results[c*18+17], chan_results[c*18 +: 12]}, {1'b1, v});
      end
   endtask : pass_check

   // seq 0 flags per conversion, seq 1 only after the whole pass
   task automatic flag_mode(input int s);
      logic [11:0] v;
      v = 12'h200 + s[11:0];
      seq_enable = 2'b00;
      first_conversion_sequence = 12'h014;
      second_conversion_sequence = 12'h014;
      seq_irq_per_seq = (s == 1) ? 2'b10 : 2'b00;
      block_irq_en = 3'b011;
      status_clear = 6'h3f;
      tick(1);
      status_clear = 6'h00;
      sample_in = v;
      seq_enable[s] = 1'b1;
      seq_sw_start[s] = 1'b1;
      tick(1);
      seq_sw_start = 2'b00;
      wait_obs(s, 1);
      tick(2);
      check(status_flags[`ASC_ST_SEQ0_IRQ+s], s == 0);
      check(irq, s == 0);
      wait_obs(s, 2);
      tick(2);
      check(status_flags[`ASC_ST_SEQ0_IRQ+s], 1);
      check(irq, 1);
      check({obs[s][0], obs[s][1]}, {4'h2, v, 4'h4, v});
      obs[s].delete();
      status_clear = 6'h3f;
      tick(1);
      status_clear = 6'h00;
      tick(1);
      check(status_flags, 0);
      check(irq, 0);
      block_irq_en = 3'b000;
      $display("test flag mode %0d done", s);
   endtask : flag_mode

   initial begin
      void'($urandom(32'h00691a0d));
      rst = 1'b1;
      sample_in = 12'h000;
      {seq_enable, seq_sw_start, continuous_cycling, seq_high_prio} = 8'h00;
      {trig_pin, trig_rising, seq_irq_per_seq} = 6'h00;
      first_conversion_sequence = 12'h000;
      second_conversion_sequence = 12'h000;
      limit_window_zero_low = 12'h000;
      limit_window_zero_high = 12'hfff;
      limit_window_one_low = 12'h100;
      limit_window_one_high = 12'h200;
      {limit_window_one_sel, thr_flag_clear, thr_mode} = 48'h0;
      {block_irq_en, status_clear, cal_start} = 10'h000;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      cal_start = 1'b1;
      tick(1);
      cal_start = 1'b0;
      check(cal_busy, 1);
      tick(1);
      for (int t = 0; t < 200 && cal_busy !== 1'b0; t++) tick(1);
      check(cal_ok, 1);
      $display("test calibration done");
      // triggers of every kind while both sequences are off
      first_conversion_sequence = 12'h00a;
      second_conversion_sequence = 12'h00a;
      sample_in = 12'h123;
      seq_sw_start = 2'b11;
      trig_pin = 2'b11;
      tick(1);
      seq_sw_start = 2'b00;
      tick(4);
      trig_pin = 2'b00;
      tick(80);
      check(obs[0].size() + obs[1].size(), 0);
      $display("test disabled done");
      m = 12'($urandom) | 12'h801;
      smp = 12'($urandom);
      sample_in = smp;
      first_conversion_sequence = m;
      seq_enable = 2'b01;
      seq_sw_start = 2'b01;
      tick(1);
      seq_sw_start = 2'b00;
      pass_check(0, m, smp);
      tick(40);
      check(obs[0].size(), 0);
      $display("test software start done");
      for (int s = 0; s < 2; s++) flag_mode(s);
      // polarity changed only while the sequence is off, so no false edge
      second_conversion_sequence = 12'h009;
      for (int p = 0; p < 2; p++) begin
         seq_enable = 2'b00;
         trig_rising[1] = p[0];
         trig_pin[1] = p[0];
         tick(5);
         seq_enable = 2'b10;
         smp = 12'h400 + p[11:0];
         sample_in = smp;
         trig_pin[1] = ~p[0];
         tick(60);
         check(obs[1].size(), 0);
         trig_pin[1] = p[0];
         pass_check(1, 12'h009, smp);
         tick(60);
         check(obs[1].size(), 0);
      end
      $display("test hardware trigger done");
      seq_enable = 2'b00;
      first_conversion_sequence = 12'h00a;
      smp = 12'h5a5;
      sample_in = smp;
      tick(2);
      seq_enable = 2'b01;
      continuous_cycling = 2'b01;
      wait_obs(0, 2);
      seq_sw_start = 2'b01;
      trig_pin[0] = 1'b1;
      tick(1);
      seq_sw_start = 2'b00;
      trig_pin[0] = 1'b0;
      // stop while channel 3 of the third pass is converting
      wait_obs(0, 5);
      continuous_cycling = 2'b00;
      tick(100);
      check(obs[0].size(), 6);
      foreach (obs[0][i]) check(obs[0][i], {i[0] ? 4'h3 : 4'h1, smp});
      obs[0].delete();
      $display("test continuous cycling done");
      seq_enable = 2'b00;
      second_conversion_sequence = 12'h020;
      limit_window_one_sel = 12'h020;
      tick(2);
      seq_enable = 2'b10;
      for (int r = 0; r < 5; r++) begin
         thr_mode = 24'h0;
         thr_mode[11:10] = tmode[r];
         sample_in = tsmp[r];
         seq_sw_start = 2'b10;
         tick(1);
         seq_sw_start = 2'b00;
         pass_check(1, 12'h020, tsmp[r]);
         check(thr_flags[5], texp[r]);
         check(status_flags[`ASC_ST_THR_IRQ], texp[r]);
         thr_flag_clear = 12'h020;
         status_clear = 6'h3f;
         tick(1);
         thr_flag_clear = 12'h000;
         status_clear = 6'h00;
         tick(1);
         check(thr_flags, 0);
      end
      $display("test thresholds done");
      // seq 1 marked high priority cuts into a running seq 0 pass, which then restarts
      seq_enable = 2'b00;
      first_conversion_sequence = 12'h00e;
      second_conversion_sequence = 12'h001;
      seq_high_prio = 2'b10;
      smp = 12'($urandom);
      sample_in = smp;
      tick(2);
      seq_enable = 2'b11;
      seq_sw_start = 2'b01;
      tick(1);
      seq_sw_start = 2'b00;
      wait_obs(0, 1);
      seq_sw_start = 2'b10;
      tick(1);
      seq_sw_start = 2'b00;
      wait_obs(1, 1);
      check(obs[0].size(), 2);
      check(obs[1][0], {4'h0, smp});
      wait_obs(0, 5);
      tick(60);
      check(obs[0].size(), 5);
      foreach (obs[0][i]) check(obs[0][i], {4'(i < 2 ? i + 1 : i - 1), smp});
      $display("test priority done");
      end_of_test();
   end
endmodule : tb_asc_seq_ctrl
